// ==== rtl/mdio_frame.sv ====
/*
 * Serial management frame engine: decodes read and write frames and
 * drives read data back. Assumes mdc is much slower than mclk.
 */
`default_nettype none
module mdio_frame (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        clkEn,
	input wire logic        mdc,
	input wire logic        mdioIn,
	input wire logic [4:0]  phyAddr,
	input wire logic [15:0] rdData,
	output logic            mdioOut,
	output logic            mdioOe,
	output logic [4:0]      regAddr,
	output logic [15:0]     wrData,
	output logic            wrStrobe
);
	import phy_mgmt_pkg::*;
	logic mdcMeta_q, mdcSync_q, mdcLast_q, dMeta_q, dSync_q;
	logic [5:0] cnt_q;
	logic [11:0] hdr_q, hdrNext;
	logic [15:0] shift_q;
	logic isRead_q, isWrite_q;
	mdio_state_t state_q;
	logic rise;

	// both pins pass two flops before any use
	always_ff @(posedge mclk) begin
		if (srst) begin
			{mdcMeta_q, mdcSync_q, mdcLast_q} <= 3'h0;
			{dMeta_q, dSync_q} <= 2'h0;
		end else if (clkEn) begin
			mdcMeta_q <= mdc;
			mdcSync_q <= mdcMeta_q;
			mdcLast_q <= mdcSync_q;
			dMeta_q <= mdioIn;
			dSync_q <= dMeta_q;
		end
	end
	assign rise = mdcSync_q & ~mdcLast_q;
	assign hdrNext = {hdr_q[10:0], dSync_q};

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= sPre;
			cnt_q <= 6'h0;
			hdr_q <= 12'h0;
			shift_q <= 16'h0;
			{isRead_q, isWrite_q} <= 2'h0;
			{mdioOut, mdioOe, wrStrobe} <= 3'h0;
			regAddr <= 5'h00;
			wrData <= 16'h0000;
		end else if (clkEn) begin
			wrStrobe <= 1'b0;
			if (rise) begin
				unique case (state_q)
					sPre: begin
						if (dSync_q) begin
							if (cnt_q != PRE_BITS)
								cnt_q <= cnt_q + 6'h1;
						end else begin
							if (cnt_q == PRE_BITS)
								state_q <= sStart;
							cnt_q <= 6'h0;
						end
					end
					sStart: begin
						state_q <= dSync_q ? sHdr : sPre;
					end
					sHdr: begin
						hdr_q <= hdrNext;
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == HDR_LAST) begin
							state_q <= sTa;
							cnt_q <= 6'h0;
							regAddr <= hdrNext[4:0];
							isRead_q <= hdrNext[11:10] == OP_READ && hdrNext[9:5] == phyAddr;
							isWrite_q <= hdrNext[11:10] == OP_WRITE && hdrNext[9:5] == phyAddr;
						end
					end
					sTa: begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'h0) begin
							// second turnaround bit driven low
							mdioOe <= isRead_q;
							mdioOut <= 1'b0;
							shift_q <= rdData;
						end else begin
							state_q <= sData;
							cnt_q <= 6'h0;
							mdioOut <= isRead_q & shift_q[15];
							shift_q <= {shift_q[14:0], 1'b0};
						end
					end
					sData: begin
						cnt_q <= cnt_q + 6'h1;
						if (isRead_q) begin
							mdioOut <= shift_q[15];
							shift_q <= {shift_q[14:0], 1'b0};
						end else begin
							shift_q <= {shift_q[14:0], dSync_q};
						end
						if (cnt_q == DATA_LAST) begin
							state_q <= sPre;
							cnt_q <= 6'h0;
							mdioOe <= 1'b0;
							mdioOut <= 1'b0;
							wrStrobe <= isWrite_q;
							wrData <= {shift_q[14:0], dSync_q};
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/mii_gate.sv ====
/*
 * MII side gating: isolate, power-down, loopback and collision test.
 * Assumes the core side signals are on mclk; MAC pins are not.
 */
`default_nettype none
module mii_gate (
	input wire logic       mclk,
	input wire logic       srst,
	input wire logic       clkEn,
	input wire logic       isolate,
	input wire logic       powerDown,
	input wire logic       loopback,
	input wire logic       collisionTest,
	input wire logic       deadTime,
	input wire logic       txEnPin,
	input wire logic       txErPin,
	input wire logic [3:0] txdPin,
	input wire logic       coreTxClk,
	input wire logic       coreRxClk,
	input wire logic       coreRxDv,
	input wire logic       coreRxEr,
	input wire logic [3:0] coreRxd,
	input wire logic       coreCol,
	input wire logic       coreCrs,
	output logic           coreTxEn,
	output logic           coreTxEr,
	output logic [3:0]     coreTxd,
	output logic [9:0]     miiPins,
	output logic           miiOe
);
	logic [5:0] txMeta_q, txSync_q;
	logic txEn, txEr, quiet;
	logic [3:0] txd;

	// mac pins are synchronised before use
	always_ff @(posedge mclk) begin
		if (srst) begin
			txMeta_q <= 6'h00;
			txSync_q <= 6'h00;
		end else if (clkEn) begin
			txMeta_q <= {txEnPin, txErPin, txdPin};
			txSync_q <= txMeta_q;
		end
	end
	assign {txEn, txEr, txd} = txSync_q;
	// power-down holds everything still instead of letting it chatter
	assign quiet = isolate | powerDown;

	always_ff @(posedge mclk) begin
		if (srst) begin
			{coreTxEn, coreTxEr, coreTxd} <= 6'h00;
		end else if (clkEn) begin
			{coreTxEn, coreTxEr, coreTxd} <= quiet ? 6'h00 : txSync_q;
		end
	end

	// pins: txclk, rxclk, rxdv, rxer, rxd[3:0], col, crs
	always_ff @(posedge mclk) begin
		if (srst) begin
			miiPins <= 10'h000;
			miiOe <= 1'b0;
		end else if (clkEn) begin
			miiOe <= ~isolate;
			if (powerDown) begin
				miiPins <= 10'h000;
			end else if (loopback) begin
				miiPins <= {coreTxClk, coreRxClk, txEn & ~deadTime, txEr & ~deadTime,
					deadTime ? 4'h0 : txd, collisionTest & txEn, txEn};
			end else begin
				miiPins <= {coreTxClk, coreRxClk, coreRxDv, coreRxEr, coreRxd,
					collisionTest ? txEn : coreCol, coreCrs};
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/phy_basic_mode_control.sv ====
/*
 * Management register set of a 10/100 PHY around the basic mode control
 * register, reached over serial management frames.
 * Assumes the negotiator and data core run on mclk; mdc, mdio, straps and
 * MAC transmit pins are asynchronous.
 */
// Function
// - bit 15 resets all registers to defaults, reads one while busy.
// - bit 14 enables loopback, default zero.
// - loopback at 100 Mbps blanks receive data up to 1300 ms.
// - bit 13 selects 100 or 10 Mbps, default one.
// - with negotiation on, speed reads the negotiated result.
// - bit 12 enables negotiation, default one; speed and duplex follow it.
// - bit 11 powers down; management still answers.
// - no spurious MII transitions entering or during power-down.
// - bit 10 isolates: transmit inputs ignored, outputs tri-stated.
// - isolated device still answers management frames.
// - bit 9 restarts negotiation, reads one until negotiation starts.
// - restart has no effect with negotiation disabled.
// - writing restart zero never disturbs running negotiation.
// - bit 8 full duplex, default one; negotiated value while enabled.
// - strap fields capture pins at reset; permanent fields are fixed.
// - bit 7 collision test; bits 6:0 reserved, read zero.
`default_nettype none
module phy_basic_mode_control #(
	parameter int DEAD_CNT = phy_mgmt_pkg::DEAD_CYCLES
) (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        clkEn,
	input wire logic        mdc,
	input wire logic        mdioIn,
	output logic            mdioOut,
	output logic            mdioOe,
	input wire logic [4:0]  phyAddrStrap,
	input wire logic        anegSpeed100,
	input wire logic        anegFullDuplex,
	input wire logic        anegStarted,
	input wire logic [15:0] lpAbility,
	input wire logic [15:0] anegExpansion,
	output logic            anegEnable,
	output logic            anegRestart,
	output logic            speed100,
	output logic            fullDuplex,
	output logic            loopback,
	output logic            powerDown,
	output logic            isolate,
	output logic            collisionTest,
	input wire logic        txEnPin,
	input wire logic        txErPin,
	input wire logic [3:0]  txdPin,
	input wire logic        coreTxClk,
	input wire logic        coreRxClk,
	input wire logic        coreRxDv,
	input wire logic        coreRxEr,
	input wire logic [3:0]  coreRxd,
	input wire logic        coreCol,
	input wire logic        coreCrs,
	output logic            coreTxEn,
	output logic            coreTxEr,
	output logic [3:0]      coreTxd,
	output logic [9:0]      miiPins,
	output logic            miiOe
);
	import phy_mgmt_pkg::*;

	localparam int DW = $clog2(DEAD_CNT + 1);

	logic [4:0]  regAddr;
	logic [15:0] wrData;
	logic        wrStrobe;
	logic [15:0] rdData;
	logic        wrBmc;
	logic        busy;
	logic        softRst;
	logic        initAll;
	logic        loop_q;
	logic        loopLast_q;
	logic        speed_q;
	logic        anen_q;
	logic        pdown_q;
	logic        iso_q;
	logic        duplex_q;
	logic        coltest_q;
	logic        restart_q;
	logic [4:0]  srstCnt_q;
	logic [4:0]  strapMeta_q;
	logic [4:0]  strapSync_q;
	logic [4:0]  phyAddr_q;
	logic [DW-1:0] dead_q;
	logic        deadNow;
	logic [1:0]  initDly_q;
	logic [15:0] vreg_q [VREG_N];
	logic [VREG_N-1:0] vhit;
	logic [15:0] vrd;

	mdio_frame u_mdio (
		.mclk     (mclk),
		.srst     (srst),
		.clkEn    (clkEn),
		.mdc      (mdc),
		.mdioIn   (mdioIn),
		.phyAddr  (phyAddr_q),
		.rdData   (rdData),
		.mdioOut  (mdioOut),
		.mdioOe   (mdioOe),
		.regAddr  (regAddr),
		.wrData   (wrData),
		.wrStrobe (wrStrobe)
	);

	mii_gate u_mii (
		.mclk          (mclk),
		.srst          (srst),
		.clkEn         (clkEn),
		.isolate       (iso_q),
		.powerDown     (pdown_q),
		.loopback      (loop_q),
		.collisionTest (coltest_q),
		.deadTime      (deadNow),
		.txEnPin       (txEnPin),
		.txErPin       (txErPin),
		.txdPin        (txdPin),
		.coreTxClk     (coreTxClk),
		.coreRxClk     (coreRxClk),
		.coreRxDv      (coreRxDv),
		.coreRxEr      (coreRxEr),
		.coreRxd       (coreRxd),
		.coreCol       (coreCol),
		.coreCrs       (coreCrs),
		.coreTxEn      (coreTxEn),
		.coreTxEr      (coreTxEr),
		.coreTxd       (coreTxd),
		.miiPins       (miiPins),
		.miiOe         (miiOe)
	);

	// writes during the soft reset window are dropped, so the
	// register set comes out of it in a known state
	assign busy = srstCnt_q != 5'h00;
	assign wrBmc = wrStrobe && regAddr == REG_BMC && !busy;
	assign softRst = clkEn && wrBmc && wrData[B_RESET];
	assign initAll = srst || softRst;

	always_ff @(posedge mclk) begin
		if (srst) begin
			srstCnt_q <= 5'h00;
		end else if (softRst) begin
			srstCnt_q <= SRST_CYCLES;
		end else if (clkEn && busy) begin
			srstCnt_q <= srstCnt_q - 5'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (initAll) begin
			loop_q <= DEF_LOOP;
			speed_q <= DEF_SPEED;
			anen_q <= DEF_ANEN;
			pdown_q <= DEF_PDOWN;
			iso_q <= DEF_ISO;
			duplex_q <= DEF_DUPLEX;
			coltest_q <= DEF_COLTEST;
		end else if (clkEn && wrBmc) begin
			loop_q <= wrData[B_LOOP];
			speed_q <= wrData[B_SPEED];
			anen_q <= wrData[B_ANEN];
			pdown_q <= wrData[B_PDOWN];
			iso_q <= wrData[B_ISO];
			duplex_q <= wrData[B_DUPLEX];
			coltest_q <= wrData[B_COLTEST];
		end
	end

	always_ff @(posedge mclk) begin
		if (initAll) begin
			restart_q <= 1'b0;
		end else if (clkEn) begin
			if (wrBmc && wrData[B_RESTART] && wrData[B_ANEN]) begin
				restart_q <= 1'b1; // set wins over a same-cycle start
			end else if (anegStarted || !anen_q) begin
				restart_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (clkEn || srst) begin
			strapMeta_q <= phyAddrStrap;
			strapSync_q <= strapMeta_q;
		end
	end
	// a short reset ends before the strap pair is full, so the capture
	// goes on loading until initAll has passed both stages
	always_ff @(posedge mclk) begin
		if (clkEn || initAll) begin
			initDly_q <= {initDly_q[0], initAll};
		end
	end
	always_ff @(posedge mclk) begin
		if (initAll || (clkEn && initDly_q != 2'h0)) begin
			phyAddr_q <= strapSync_q; // pins must be steady through reset
		end
	end

	// the entry cycle counts as dead too, before the counter is
	// loaded, so not one looped beat leaks out at 100 Mbps
	assign deadNow = dead_q != '0 || (loop_q && !loopLast_q && speed100);

	always_ff @(posedge mclk) begin
		if (initAll) begin
			dead_q <= '0;
			loopLast_q <= 1'b0;
		end else if (clkEn) begin
			loopLast_q <= loop_q;
			if (!loop_q) begin
				dead_q <= '0;
			end else if (!loopLast_q && speed100) begin
				dead_q <= DW'(DEAD_CNT);
			end else if (dead_q != '0) begin
				dead_q <= dead_q - DW'(1);
			end
		end
	end

	// vendor registers: plain storage, one entry per number
	generate
		for (genvar i = 0; i < VREG_N; i++) begin : g_vreg
			assign vhit[i] = regAddr == VREG_ADDR[i];
			always_ff @(posedge mclk) begin
				if (initAll) begin
					vreg_q[i] <= VREG_DEF;
				end else if (clkEn && wrStrobe && vhit[i] && !busy) begin
					vreg_q[i] <= wrData;
				end
			end
		end
	endgenerate

	always_comb begin
		vrd = 16'h0000;
		for (int i = 0; i < VREG_N; i++) begin
			if (vhit[i])
				vrd = vreg_q[i];
		end
	end

	assign speed100 = anen_q ? anegSpeed100 : speed_q;
	assign fullDuplex = anen_q ? anegFullDuplex : duplex_q;
	assign anegEnable = anen_q;
	assign anegRestart = restart_q;
	assign loopback = loop_q;
	assign powerDown = pdown_q;
	assign isolate = iso_q;
	assign collisionTest = coltest_q;

	always_comb begin
		rdData = 16'h0000;
		case (regAddr)
			REG_BMC: begin
				rdData[B_RESET] = busy;
				rdData[B_LOOP] = loop_q;
				rdData[B_SPEED] = speed100;
				rdData[B_ANEN] = anen_q;
				rdData[B_PDOWN] = pdown_q;
				rdData[B_ISO] = iso_q;
				rdData[B_RESTART] = restart_q;
				rdData[B_DUPLEX] = fullDuplex;
				rdData[B_COLTEST] = coltest_q;
			end
			REG_LPA: rdData = lpAbility;
			REG_ANX: rdData = anegExpansion;
			REG_VCS: begin
				rdData = vrd;
				rdData[ADDR_MSB:ADDR_LSB] = phyAddr_q;
			end
			default: rdData = vrd;
		endcase
	end
endmodule
`default_nettype wire

// ==== rtl/phy_mgmt_pkg.sv ====
/*
 * Constants shared by the management register block: register numbers,
 * control bit positions, defaults, frame layout and timing.
 * Assumes a 10 MHz mclk.
 */
`default_nettype none
package phy_mgmt_pkg;
	// register numbers
	localparam logic [4:0] REG_BMC = 5'h00;
	localparam logic [4:0] REG_LPA = 5'h05;
	localparam logic [4:0] REG_ANX = 5'h06;
	localparam logic [4:0] REG_VCS = 5'h11;
	localparam int VREG_N = 7;
	localparam logic [4:0] VREG_ADDR [VREG_N] = '{
		5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h1b, 5'h1d};
	// control bit positions
	localparam int B_RESET = 15;
	localparam int B_LOOP = 14;
	localparam int B_SPEED = 13;
	localparam int B_ANEN = 12;
	localparam int B_PDOWN = 11;
	localparam int B_ISO = 10;
	localparam int B_RESTART = 9;
	localparam int B_DUPLEX = 8;
	localparam int B_COLTEST = 7;
	// phy address field in the vendor status register
	localparam int ADDR_LSB = 4;
	localparam int ADDR_MSB = 8;
	// control defaults
	localparam logic DEF_LOOP = 1'b0;
	localparam logic DEF_SPEED = 1'b1;
	localparam logic DEF_ANEN = 1'b1;
	localparam logic DEF_PDOWN = 1'b0;
	localparam logic DEF_ISO = 1'b0;
	localparam logic DEF_DUPLEX = 1'b1;
	localparam logic DEF_COLTEST = 1'b0;
	localparam logic [15:0] VREG_DEF = 16'h0000;
	// management frame layout
	localparam logic [5:0] PRE_BITS = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h0b;
	localparam logic [5:0] DATA_LAST = 6'h0f;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int DEAD_MS = 1300;
	localparam int DEAD_CYCLES = DEAD_MS * (CLK_HZ / 1000);
	localparam logic [4:0] SRST_CYCLES = 5'h10;
	typedef enum logic [2:0] {sPre, sStart, sHdr, sTa, sData} mdio_state_t;
endpackage
`default_nettype wire

// ==== test/mgmt_master.sv ====
/*
 * Station management model: sends read and write frames on mdc and mdio.
 * Assumes the bench resolves the shared mdio wire with a pull-up.
 */
`default_nettype none
module mgmt_master (
	input wire logic mclk,
	input wire logic mdioWire,
	output logic     mdc,
	output logic     mdioDrv,
	output logic     mdioEn
);
	timeunit 1ns;
	timeprecision 100ps;
	int halfPer = 5;
	// mdc stands low and mdio is released between frames
	initial begin
		mdc = 1'b0;
		mdioDrv = 1'b0;
		mdioEn = 1'b0;
	end
	// drive in the low half, sample just before the rise
	task automatic bitCycle(input logic d, input logic en, output logic s);
		@(negedge mclk);
		mdc = 1'b0;
		mdioDrv = d;
		mdioEn = en;
		repeat (halfPer) @(negedge mclk);
		s = mdioWire;
		mdc = 1'b1;
		repeat (halfPer - 1) @(negedge mclk);
	endtask
	// preamble, start, opcode, addresses, turnaround, 16 data bits
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] seq;
		logic        s;
		seq = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
		for (int i = 63; i >= 0; i--) begin
			bitCycle(seq[i], !(op == 2'h2 && i < 18), s);
			if (i < 16)
				rd[i] = s;
		end
		@(negedge mclk);
		mdc = 1'b0;
		mdioEn = 1'b0;
		repeat (halfPer) @(negedge mclk);
	endtask
endmodule
`default_nettype wire

// ==== test/phy_basic_mode_control_bench.sv ====
/*
 * Self-checking bench for the basic mode control block.
 * Assumes the management model mgmt_master and a pulled-up mdio wire.
 */
`default_nettype none
module phy_basic_mode_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk;
	logic        srst;
	logic        clkEn;
	logic        anegSpeed100;
	logic        anegFullDuplex;
	logic        anegStarted;
	logic [5:0]  txIn;
	logic [9:0]  coreIn;
	logic [4:0]  strap;
	logic [4:0]  phyAddr;
	logic [15:0] word;
	wire         mdc, mdioIn, mdioOut, mdioOe, mDrv, mEn, anegEnable, anegRestart;
	wire         speed100, fullDuplex, loopback, powerDown, isolate, collisionTest;
	wire         coreTxEn, coreTxEr, miiOe;
	wire [3:0]   coreTxd;
	wire [9:0]   miiPins;
	int          failures;
	int          samplesChecked;
	int          cycles;
	phy_basic_mode_control #(.DEAD_CNT(20)) uut (
		.mclk, .srst, .clkEn, .mdc, .mdioIn, .mdioOut, .mdioOe,
		.phyAddrStrap(strap), .anegSpeed100, .anegFullDuplex, .anegStarted,
		.lpAbility(16'h5a5a), .anegExpansion(16'h0007), .anegEnable, .anegRestart,
		.speed100, .fullDuplex, .loopback, .powerDown, .isolate, .collisionTest,
		.txEnPin(txIn[5]), .txErPin(txIn[4]), .txdPin(txIn[3:0]),
		.coreTxClk(coreIn[9]), .coreRxClk(coreIn[8]), .coreRxDv(coreIn[7]),
		.coreRxEr(coreIn[6]), .coreRxd(coreIn[5:2]), .coreCol(coreIn[1]),
		.coreCrs(coreIn[0]), .coreTxEn, .coreTxEr, .coreTxd, .miiPins, .miiOe);
	mgmt_master mac (.mclk, .mdioWire(mdioIn), .mdc, .mdioDrv(mDrv), .mdioEn(mEn));
	// mdio floats high through its pull-up when nobody drives it
	assign mdioIn = mdioOe ? mdioOut : (mEn ? mDrv : 1'b1);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		samplesChecked++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic flag(input string what, input logic e, input logic g);
		check(what, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		mac.frame(2'h1, phyAddr, ra, d, x);
	endtask
	task automatic rdChk(input logic [4:0] ra, input logic [15:0] e);
		logic [15:0] x;
		mac.frame(2'h2, phyAddr, ra, 16'h0000, x);
		check("register read", e, x);
	endtask
	task automatic completeRun();
		$display("checks %0d mismatches %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// a hang is cut short; the tests need about 22k cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			$display("timeout after %0d cycles", cycles);
			completeRun();
		end
	end
	initial begin
		srst = 1'b1;
		clkEn = 1'b1;
		{anegSpeed100, anegFullDuplex, anegStarted} = 3'h0;
		txIn = 6'h00;
		coreIn = 10'h000;
		strap = 5'h0b;
		phyAddr = 5'h0b;
		repeat (2) @(negedge mclk);
		srst = 1'b0;
		// defaults, negotiated reflection, read-only and unmapped places
		rdChk(5'h00, 16'h1000);
		{anegSpeed100, anegFullDuplex} = 2'h3;
		rdChk(5'h00, 16'h3100);
		rdChk(5'h11, 16'h00b0);
		rdChk(5'h05, 16'h5a5a);
		rdChk(5'h06, 16'h0007);
		rdChk(5'h02, 16'h0000);
		$display("test defaults done");
		{anegSpeed100, anegFullDuplex} = 2'h0;
		wr(5'h00, 16'h00ff);
		rdChk(5'h00, 16'h0080);
		flag("collisionTest", 1'b1, collisionTest);
		wr(5'h00, 16'h2100);
		rdChk(5'h00, 16'h2100);
		flag("speed100", 1'b1, speed100);
		flag("fullDuplex", 1'b1, fullDuplex);
		$display("test forced mode done");
		wr(5'h00, 16'h0200);
		rdChk(5'h00, 16'h0000);
		wr(5'h00, 16'h1200);
		flag("anegRestart", 1'b1, anegRestart);
		flag("anegEnable", 1'b1, anegEnable);
		wr(5'h00, 16'h1000);
		rdChk(5'h00, 16'h1200);
		anegStarted = 1'b1;
		@(negedge mclk);
		anegStarted = 1'b0;
		rdChk(5'h00, 16'h1000);
		$display("test restart done");
		// transmit active while isolated, slow management clock
		txIn = 6'h2f;
		wr(5'h00, 16'h0400);
		flag("miiOe", 1'b0, miiOe);
		flag("isolate", 1'b1, isolate);
		flag("coreTxEn", 1'b0, coreTxEn);
		mac.halfPer = 8;
		rdChk(5'h00, 16'h0400);
		mac.halfPer = 5;
		coreIn = 10'h3ff;
		wr(5'h00, 16'h0800);
		check("miiPins", 16'h0000, {6'h00, miiPins});
		flag("powerDown", 1'b1, powerDown);
		rdChk(5'h00, 16'h0800);
		wr(5'h00, 16'h2000);
		flag("coreTxEn", 1'b1, coreTxEn);
		flag("miiOe", 1'b1, miiOe);
		check("coreTxd", 16'h000f, {12'h000, coreTxd});
		flag("coreTxEr", 1'b0, coreTxEr);
		// a frozen clock enable must hold the synchronised transmit state
		clkEn = 1'b0;
		txIn = 6'h00;
		repeat (4) @(negedge mclk);
		flag("frozenTxEn", 1'b1, coreTxEn);
		txIn = 6'h2f;
		clkEn = 1'b1;
		wr(5'h00, 16'h6000);
		flag("rxdvBlank", 1'b0, miiPins[7]);
		rdChk(5'h00, 16'h6000);
		flag("rxdvLoop", 1'b1, miiPins[7]);
		$display("test isolate and loopback done");
		wr(5'h10, 16'hbeef);
		wr(5'h02, 16'h1234);
		rdChk(5'h02, 16'h0000);
		mac.frame(2'h1, 5'h04, 5'h10, 16'h0000, word);
		mac.frame(2'h2, 5'h04, 5'h10, 16'h0000, word);
		check("foreignRead", 16'hffff, word);
		rdChk(5'h10, 16'hbeef);
		strap = 5'h15;
		wr(5'h00, 16'h8000);
		phyAddr = 5'h15;
		rdChk(5'h00, 16'h1000);
		rdChk(5'h10, 16'h0000);
		rdChk(5'h11, 16'h0150);
		flag("loopback", 1'b0, loopback);
		$display("test soft reset done");
		completeRun();
	end
endmodule
`default_nettype wire

// ==== test/phy_bmc_asserts.sv ====
/*
 * Checker for the basic mode control block, bound to its top ports.
 * Assumes clkEn drops only between frames, and an mdc period of at least eight mclk.
 */
`default_nettype none
module phy_bmc_asserts (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        anegSpeed100,
	input wire logic        anegFullDuplex,
	input wire logic        anegStarted,
	input wire logic        anegEnable,
	input wire logic        anegRestart,
	input wire logic        speed100,
	input wire logic        fullDuplex,
	input wire logic        loopback,
	input wire logic        powerDown,
	input wire logic        isolate,
	input wire logic        collisionTest,
	input wire logic        mdioOut,
	input wire logic        mdioOe,
	input wire logic        coreTxEn,
	input wire logic        coreTxEr,
	input wire logic [3:0]  coreTxd,
	input wire logic [9:0]  miiPins,
	input wire logic        miiOe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	// control outputs, negotiation and mii gating
	chk_reset_defaults:
	assert property ($fell(srst) |-> anegEnable && !loopback && !powerDown && !isolate
		&& !anegRestart && !collisionTest) else $error("control defaults wrong");
	chk_speed_follow:
	assert property (anegEnable |-> speed100 == anegSpeed100) else $error("speed not negotiated");
	chk_duplex_follow:
	assert property (anegEnable |-> fullDuplex == anegFullDuplex)
		else $error("duplex not negotiated");
	chk_restart_done:
	assert property (anegRestart && anegStarted |=> !anegRestart) else $error("restart stuck");
	chk_restart_idle:
	assert property (!anegEnable && !$past(anegEnable) |-> !anegRestart)
		else $error("restart while disabled");
	chk_pdown_quiet:
	assert property (powerDown |=> miiPins == 10'h000) else $error("mii active in power-down");
	chk_oe_follows:
	assert property (!$past(srst) |-> miiOe == !$past(isolate)) else $error("mii enable wrong");
	chk_tx_gated:
	assert property (isolate || powerDown |=> !coreTxEn && !coreTxEr && coreTxd == 4'h0)
		else $error("transmit not gated");
	// management read drive: zero turnaround bit, then enable held eight cycles; loopback receive blanking
	chk_ta_zero:
	assert property ($rose(mdioOe) |-> !mdioOut) else $error("turnaround bit not zero");
	chk_drive_hold:
	assert property ($rose(mdioOe) |=> mdioOe [*8]) else $error("read drive too short");
	chk_dead_blank:
	assert property ($rose(loopback) && speed100 |=> (miiPins[7:2] == 6'h00) [*8])
		else $error("receive not blanked");
endmodule
bind phy_basic_mode_control phy_bmc_asserts chk (.mclk, .srst, .anegSpeed100, .anegFullDuplex,
	.anegStarted, .anegEnable, .anegRestart, .speed100, .fullDuplex, .loopback, .powerDown,
	.isolate, .collisionTest, .mdioOut, .mdioOe, .coreTxEn, .coreTxEr, .coreTxd, .miiPins,
	.miiOe);
`default_nettype wire
